// [src/vdpi_pkg.sv]
// Package: constants and state layout for the video DAC pixel input register
package vdpi_pkg;

	// ------------------------------------------------------------
	// Code layout
	// ------------------------------------------------------------
	localparam int          CODE_W     = 10;
	localparam int          LEVELS     = 1024;
	localparam logic [9:0]  CODE_WHITE = 10'h3FF;
	localparam logic [9:0]  CODE_BLACK = 10'h000;
	localparam logic [9:0]  CODE_RST   = 10'h000;
	localparam int          BUF_DEPTH  = 2;

	// ------------------------------------------------------------
	// Operating modes
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		VDPI_OFF,
		VDPI_STANDBY,
		VDPI_ACTIVE
	} vdpi_mode_e;

endpackage : vdpi_pkg

// [src/vdpi_skid_buf.sv]
// Two-entry valid/ready buffer for pixel codes
`timescale 1ns/1ps
`default_nettype none
module vdpi_skid_buf #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	// Filling side
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output var  logic             in_ready,
	// Draining side
	output var  logic             out_valid,
	output var  logic [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               rd;
		logic [PW-1:0]               wr;
		logic [PW:0]                 cnt;
		logic                        rdy;
	} vdpi_buf_s;

	vdpi_buf_s st;
	vdpi_buf_s next_st;
	logic      push;
	logic      pop;

	always_comb begin
		// Registered not-full flag, exact for each coming edge but the first after reset
		in_ready  = st.rdy;
		out_valid = (st.cnt != '0);
		out_data  = st.mem[st.rd];
		push      = in_valid && in_ready;
		pop       = out_valid && out_ready;
		next_st   = st;
		if (push) begin
			next_st.mem[st.wr] = in_data;
			next_st.wr         = (st.wr == PW'(DEPTH-1)) ? '0 : st.wr + 1'b1;
		end
		if (pop) begin
			next_st.rd = (st.rd == PW'(DEPTH-1)) ? '0 : st.rd + 1'b1;
		end
		next_st.cnt = st.cnt + (PW+1)'(push) - (PW+1)'(pop);
		next_st.rdy = (next_st.cnt != (PW+1)'(DEPTH));
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule : vdpi_skid_buf
`default_nettype wire

// [src/vdpi_top.sv]
// Pixel input register and segmented decoder front end of a 10-bit video DAC
// How it works
// - A rising clock edge captures all ten code bits only when active mode takes a buffered word.
// - One channel, one 10-bit storage register feeds the converter.
// - The converter resolves codes into 1024 distinct levels.
// - Control inputs are sampled on the rising clock edge, like data.
// - 0x3FF gives white, 0x000 black; complement is full scale minus main while active, zero otherwise.
// - While active, each on segment steers its unit current to the main output, each off segment to the complement.
// - Code bit zero is the least significant bit.
// - Power-off low powers the converter down, reference included; the input buffer still takes words and dac_code holds.
// - Standby low with power-off high enters standby, reference stays on.
`timescale 1ns/1ps
`default_nettype none
module vdpi_top #(
	parameter int CODE_W = vdpi_pkg::CODE_W,
	parameter int SEGS   = vdpi_pkg::LEVELS - 1
) (
	// Clock and reset
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	// Pixel stream
	input  wire logic              pixel_valid,
	input  wire logic [CODE_W-1:0] pixel_code,
	output var  logic              pixel_ready,
	// Power controls
	input  wire logic              power_off_n,
	input  wire logic              standby_n,
	// Converter side
	output var  logic [CODE_W-1:0] dac_code,
	output var  logic [SEGS-1:0]   analog_current_out,
	output var  logic [SEGS-1:0]   analog_current_out_cmp,
	output var  logic              ref_enable,
	output var  logic              dac_enable,
	output var  logic [1:0]        mode
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [CODE_W-1:0]    code;
		logic [SEGS-1:0]      seg;
		logic [SEGS-1:0]      seg_cmp;
		logic                 ref_on;
		logic                 dac_on;
		vdpi_pkg::vdpi_mode_e md;
	} vdpi_top_s;

	vdpi_top_s         st;
	vdpi_top_s         next_st;
	logic              buf_valid;
	logic [CODE_W-1:0] buf_code;
	logic              buf_ready;
	logic              buf_in_ready;

	// ------------------------------------------------------------
	// Input buffer
	// ------------------------------------------------------------
	vdpi_skid_buf #(
		.WIDTH (CODE_W),
		.DEPTH (vdpi_pkg::BUF_DEPTH)
	) u_buf (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.in_valid  (pixel_valid),
		.in_data   (pixel_code),
		.in_ready  (buf_in_ready),
		.out_valid (buf_valid),
		.out_data  (buf_code),
		.out_ready (buf_ready)
	);

	// Converter takes a word each edge only while fully powered
	assign buf_ready = (st.md == vdpi_pkg::VDPI_ACTIVE);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		next_st          = st;
		// Controls sampled on the same edge as the data
		if (!power_off_n) begin
			next_st.md = vdpi_pkg::VDPI_OFF;
		end else if (!standby_n) begin
			next_st.md = vdpi_pkg::VDPI_STANDBY;
		end else begin
			next_st.md = vdpi_pkg::VDPI_ACTIVE;
		end
		next_st.ref_on = (next_st.md != vdpi_pkg::VDPI_OFF);
		next_st.dac_on = (next_st.md == vdpi_pkg::VDPI_ACTIVE);
		// Code register loads only on a taken word, else it holds
		if (buf_valid && buf_ready) begin
			next_st.code = buf_code;
		end
		// Thermometer segments: one unit current per code step
		for (int i = 0; i < SEGS; i++) begin
			next_st.seg[i] = (CODE_W'(i) < next_st.code);
		end
		next_st.seg_cmp = ~next_st.seg;
		if (!next_st.dac_on) begin
			next_st.seg     = '0;
			next_st.seg_cmp = '0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st      <= '0;
			st.code <= vdpi_pkg::CODE_RST;
			st.md   <= vdpi_pkg::VDPI_OFF;
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Buffer's own registered not-full flag, so a stalled receiver loses no word
	assign pixel_ready            = buf_in_ready;
	assign dac_code               = st.code;
	assign analog_current_out     = st.seg;
	assign analog_current_out_cmp = st.seg_cmp;
	assign ref_enable             = st.ref_on;
	assign dac_enable             = st.dac_on;
	assign mode                   = st.md;
endmodule : vdpi_top
`default_nettype wire

// [tb/vdpi_chk.sv]
// Checker: port properties of the pixel input register
`timescale 1ns/1ps
`default_nettype none
module vdpi_chk #(parameter int SEGS = 1023) (
	input wire logic clk_sys, rst_n, pixel_valid, pixel_ready, power_off_n, standby_n,
	input wire logic [9:0] pixel_code, dac_code,
	input wire logic [SEGS-1:0] analog_current_out, analog_current_out_cmp,
	input wire logic ref_enable, dac_enable,
	input wire logic [1:0] mode);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence s_idle2; !dac_enable ##1 !dac_enable; endsequence
	property p_ref; $past(rst_n) |-> ref_enable == $past(power_off_n); endproperty
	a_ref: assert property (p_ref) else $error("reference enable wrong");
	property p_mode; $past(rst_n) |-> mode == (!$past(power_off_n) ? 2'h0 :
		!$past(standby_n) ? 2'h1 : 2'h2); endproperty
	a_mode: assert property (p_mode) else $error("mode wrong");
	property p_en; dac_enable == (mode == 2'h2); endproperty
	a_en: assert property (p_en) else $error("enable wrong");
	property p_therm; dac_enable |-> analog_current_out == ((SEGS'(1) << dac_code) - SEGS'(1));
	endproperty
	a_therm: assert property (p_therm) else $error("segments wrong");
	property p_cmp; dac_enable |-> analog_current_out_cmp == ~analog_current_out; endproperty
	a_cmp: assert property (p_cmp) else $error("complement wrong");
	property p_off; !dac_enable |-> analog_current_out == '0 && analog_current_out_cmp == '0;
	endproperty
	a_off: assert property (p_off) else $error("segments not gated");
	property p_hold; s_idle2 |-> $stable(dac_code); endproperty
	a_hold: assert property (p_hold) else $error("code moved while idle");
	property p_rdy; $rose(rst_n) |=> pixel_ready; endproperty
	a_rdy: assert property (p_rdy) else $error("ready missing");
endmodule : vdpi_chk
bind vdpi_top vdpi_chk #(.SEGS(SEGS)) vdpi_chk_inst (.*);
`default_nettype wire

// [tb/vdpi_src.sv]
// Partner model: pixel source
`timescale 1ns/1ps
`default_nettype none
module vdpi_src (input wire logic clk_sys, pixel_ready,
	output var logic pixel_valid, output var logic [9:0] pixel_code);
	initial begin
		pixel_valid = 1'h0;
		pixel_code = 10'h000;
	end
	// One word, bit 0 least significant, held over one taking edge
	task automatic push(input logic [9:0] c);
		@(negedge clk_sys);
		pixel_valid = 1'h1;
		pixel_code = c;
		// Hold until ready stands for the coming rising edge
		while (!pixel_ready) @(negedge clk_sys);
		@(negedge clk_sys);
		pixel_valid = 1'h0;
		pixel_code = ~c;
	endtask : push
endmodule : vdpi_src
`default_nettype wire

// [tb/video_dac_pixel_input_register_bench.sv]
// Testbench: scenarios for the pixel input register
`timescale 1ns/1ps
`default_nettype none
module video_dac_pixel_input_register_bench;
	logic clk_sys = 1'h0, rst_n = 1'h0, power_off_n = 1'h1, standby_n = 1'h1;
	logic pixel_valid, pixel_ready, ref_enable, dac_enable;
	logic [9:0] pixel_code, dac_code;
	logic [1022:0] analog_current_out, analog_current_out_cmp;
	logic [1:0] mode;
	logic [9:0] codes[6] = '{10'h000, 10'h3FF, 10'h001, 10'h200, 10'h155, 10'h2AA};
	int n_errors = 0, comparisons = 0, cycles = 0;
	always #4 clk_sys = ~clk_sys;
	vdpi_top vdpi_top_inst (.*);
	vdpi_src vdpi_src_inst (.*);
	task automatic chk(input string n, input logic [1022:0] s, e);
		comparisons++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic complete_run;
		$display("comparisons %0d errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : complete_run
	always @(posedge clk_sys) if (++cycles == 3000) begin
		n_errors++;
		complete_run();
	end
	task automatic t_codes;
		foreach (codes[i]) begin
			vdpi_src_inst.push(codes[i]);
			@(negedge clk_sys);
			chk("code", dac_code, codes[i]);
			chk("seg", analog_current_out, (1023'(1) << codes[i]) - 1023'(1));
			chk("cmp", analog_current_out_cmp, ~((1023'(1) << codes[i]) - 1023'(1)));
		end
	endtask : t_codes
	task automatic t_modes;
		for (int i = 0; i < 4; i++) begin
			{power_off_n, standby_n} = 2'(i);
			repeat (2) @(negedge clk_sys);
			chk("mode", mode, i[1] ? (i[0] ? 2'h2 : 2'h1) : 2'h0);
			chk("ref", ref_enable, i[1]);
			chk("dac", dac_enable, i == 3);
		end
	endtask : t_modes
	task automatic t_stall;
		standby_n = 1'h0;
		repeat (2) @(negedge clk_sys);
		vdpi_src_inst.push(10'h0F0);
		vdpi_src_inst.push(10'h30C);
		repeat (2) @(negedge clk_sys);
		chk("ready", pixel_ready, 1'h0);
		chk("held", dac_code, 10'h2AA);
		standby_n = 1'h1;
		repeat (2) @(negedge clk_sys);
		chk("first", dac_code, 10'h0F0);
		repeat (4) @(negedge clk_sys);
		chk("drain", dac_code, 10'h30C);
		chk("ready", pixel_ready, 1'h1);
	endtask : t_stall
	initial begin
		repeat (6) @(negedge clk_sys);
		chk("mode", mode, 2'h0);
		chk("ready", pixel_ready, 1'h0);
		rst_n = 1'h1;
		repeat (2) @(negedge clk_sys);
		t_codes();
		t_modes();
		t_stall();
		complete_run();
	end
endmodule : video_dac_pixel_input_register_bench
`default_nettype wire
